// ==== cdsx_exec.sv ====
// execution unit for invert, decrement and decrement-skip
module cdsx_exec
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [13:0] I_INSTR,
  input wire logic [7:0] I_FILE_RDATA,
  output logic [1:0] O_QPHASE,
  output logic [6:0] O_FILE_ADDR,
  output logic O_FILE_RD,
  output logic O_FILE_WR,
  output logic [7:0] O_FILE_WDATA,
  output logic O_ACC_WR,
  output logic [7:0] O_ACC_WDATA,
  output logic O_ZERO_WR,
  output logic O_ZERO_VAL,
  output logic O_SKIP_NOP,
  output logic O_BUSY
);
  cdsx_dec_if fld ();
  cdsx_pkg::cdsx_phase_t phase_reg;
  logic [13:0] instr_reg;
  logic [7:0] opnd_reg;
  logic [7:0] res_reg;
  logic [7:0] res_next;
  logic skip_reg;
  logic nop_cycle_reg;
  logic active;

  cdsx_decode u_dec
  (
    .i_instr(instr_reg),
    .o_fields(fld)
  );

  assign active = !nop_cycle_reg && (fld.is_inv || fld.is_dec || fld.is_dsz);

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      phase_reg <= cdsx_pkg::CDSX_Q1;
    else
    begin
      case (phase_reg)
        cdsx_pkg::CDSX_Q1: phase_reg <= cdsx_pkg::CDSX_Q2;
        cdsx_pkg::CDSX_Q2: phase_reg <= cdsx_pkg::CDSX_Q3;
        cdsx_pkg::CDSX_Q3: phase_reg <= cdsx_pkg::CDSX_Q4;
        default: phase_reg <= cdsx_pkg::CDSX_Q1;
      endcase
    end
  end

  // instruction latch at decode phase
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      instr_reg <= 14'h0000;
    else if (phase_reg == cdsx_pkg::CDSX_Q4)
      instr_reg <= I_INSTR;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      nop_cycle_reg <= 1'b0;
    else if (phase_reg == cdsx_pkg::CDSX_Q4)
      nop_cycle_reg <= skip_reg;
  end

  // operand read in second phase
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      opnd_reg <= 8'h00;
    else if (phase_reg == cdsx_pkg::CDSX_Q2 && active)
      opnd_reg <= I_FILE_RDATA;
  end

  always_comb
  begin
    if (fld.is_inv)
      res_next = ~opnd_reg;
    else
      res_next = opnd_reg - 8'h01;
  end

  // result processed in third phase
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      res_reg <= 8'h00;
    else if (phase_reg == cdsx_pkg::CDSX_Q3 && active)
      res_reg <= res_next;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
      skip_reg <= 1'b0;
    else if (phase_reg == cdsx_pkg::CDSX_Q3)
      skip_reg <= active && fld.is_dsz && (res_next == 8'h00);
    else if (phase_reg == cdsx_pkg::CDSX_Q1)
      skip_reg <= 1'b0;
  end

  always_comb
  begin
    O_FILE_WR = 1'b0;
    O_ACC_WR = 1'b0;
    O_ZERO_WR = 1'b0;
    if (phase_reg == cdsx_pkg::CDSX_Q4 && active)
    begin
      O_FILE_WR = fld.dest;
      O_ACC_WR = !fld.dest;
      O_ZERO_WR = !fld.is_dsz;
    end
  end

  assign O_QPHASE = phase_reg;
  assign O_FILE_ADDR = fld.addr;
  assign O_FILE_RD = (phase_reg == cdsx_pkg::CDSX_Q2) && active;
  assign O_FILE_WDATA = res_reg;
  assign O_ACC_WDATA = res_reg;
  assign O_ZERO_VAL = (res_reg == 8'h00);
  assign O_SKIP_NOP = nop_cycle_reg;
  assign O_BUSY = active;

  a_inv_zero_val: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (O_ZERO_WR && fld.is_inv) |-> (O_ZERO_VAL == (res_reg == 8'h00)) && (res_reg == ~opnd_reg))
    else $error("invert result wrong");

  a_phase_order: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (phase_reg == cdsx_pkg::CDSX_Q1) |=> (phase_reg == cdsx_pkg::CDSX_Q2) ##1
    (phase_reg == cdsx_pkg::CDSX_Q3) ##1 (phase_reg == cdsx_pkg::CDSX_Q4))
    else $error("quarter phase order broken");

  a_dsz_no_flag: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    fld.is_dsz |-> !O_ZERO_WR)
    else $error("skip decrement touched zero flag");

  sequence s_dsz_zero;
    (phase_reg == cdsx_pkg::CDSX_Q3) && active && fld.is_dsz && (res_next == 8'h00);
  endsequence

  a_skip_nop: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_dsz_zero |-> ##2 O_SKIP_NOP [*4])
    else $error("skip cycle missing");

  a_no_skip: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    ((phase_reg == cdsx_pkg::CDSX_Q3) && active && (res_next != 8'h00)) |-> ##2 !O_SKIP_NOP)
    else $error("spurious skip");

  a_nop_idle: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_SKIP_NOP |-> !O_FILE_WR && !O_ACC_WR && !O_ZERO_WR && !O_FILE_RD)
    else $error("activity during no-op cycle");

  a_dec_dest: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (O_FILE_WR || O_ACC_WR) && !fld.is_inv |->
    (res_reg == opnd_reg - 8'h01) && (O_FILE_WR == fld.dest))
    else $error("decrement result or destination wrong");

  a_addr_field: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_FILE_RD |-> (O_FILE_ADDR == instr_reg[6:0]) && $stable(instr_reg))
    else $error("address field wrong");

  sequence s_read_q2;
    O_FILE_RD && (phase_reg == cdsx_pkg::CDSX_Q2);
  endsequence

  sequence s_write_q4;
    (O_FILE_WR || O_ACC_WR) && (phase_reg == cdsx_pkg::CDSX_Q4);
  endsequence

  // read then write two phases later
  a_read_to_write: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_read_q2 |-> ##2 s_write_q4)
    else $error("write phase missing after read");

  // operand taken at end of read phase
  a_opnd_capture: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_read_q2 |=> (opnd_reg == $past(I_FILE_RDATA)))
    else $error("operand not captured");

  a_strobe_pulse: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (O_FILE_WR || O_ACC_WR) |-> (O_FILE_WR != O_ACC_WR) ##1 (!O_FILE_WR && !O_ACC_WR))
    else $error("destination strobe wrong");

  a_skip_writes: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_dsz_zero |=> s_write_q4 ##0 (O_FILE_WDATA == 8'h00))
    else $error("skip decrement result not written");

  a_skip_once: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_SKIP_NOP && (phase_reg == cdsx_pkg::CDSX_Q4) |=> !O_SKIP_NOP)
    else $error("no-op cycle repeated");

  // zero write only for flag ops
  a_zero_wr_ops: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_ZERO_WR |-> (phase_reg == cdsx_pkg::CDSX_Q4) && (fld.is_inv || fld.is_dec))
    else $error("zero flag write out of place");
endmodule : cdsx_exec

// ==== cdsx_pkg.sv ====
// package of constants for the complement/decrement/skip execution block
package cdsx_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam int OP_HI = 13;
  localparam int OP_LO = 8;
  localparam logic [5:0] INVERT_REG_OP = 6'h09;
  localparam logic [5:0] DEC_REG_OP = 6'h03;
  localparam logic [5:0] DEC_SKIP_IF_NULL_OP = 6'h0B;
  localparam int QPHASES = 4;
  typedef enum logic [1:0]
  {
    CDSX_Q1 = 2'b00,
    CDSX_Q2 = 2'b01,
    CDSX_Q3 = 2'b10,
    CDSX_Q4 = 2'b11
  } cdsx_phase_t;
endpackage : cdsx_pkg

// ==== cdsx_dec_if.sv ====
// interface carrying decoded instruction fields
interface cdsx_dec_if;
  logic [6:0] addr;
  logic dest;
  logic is_inv;
  logic is_dec;
  logic is_dsz;
  modport dec (output addr, output dest, output is_inv, output is_dec, output is_dsz);
  modport use_side (input addr, input dest, input is_inv, input is_dec, input is_dsz);
endinterface : cdsx_dec_if

// ==== cdsx_decode.sv ====
// field decoder for the instruction word
module cdsx_decode
(
  input wire logic [13:0] i_instr,
  cdsx_dec_if.dec o_fields
);
  logic [5:0] op;
  assign op = i_instr[cdsx_pkg::OP_HI:cdsx_pkg::OP_LO];
  assign o_fields.addr = i_instr[cdsx_pkg::ADDR_W-1:0];
  assign o_fields.dest = i_instr[cdsx_pkg::DEST_BIT];
  assign o_fields.is_inv = (op == cdsx_pkg::INVERT_REG_OP);
  assign o_fields.is_dec = (op == cdsx_pkg::DEC_REG_OP);
  assign o_fields.is_dsz = (op == cdsx_pkg::DEC_SKIP_IF_NULL_OP);
endmodule : cdsx_decode

// ==== cdsx_tb.sv ====
// self-checking bench for the invert/decrement/skip execution block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic fw; logic aw; logic [7:0] wd; logic zw; logic zv; logic sk; logic bz;
    logic [6:0] ad;} cdsx_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic [7:0] rdata = 8'h00;
  logic [1:0] qphase;
  logic [6:0] faddr;
  logic frd, fwr, awr, zwr, zval, skip, busy;
  logic [7:0] fwd, awd;
  cdsx_note_t notes[$];
  cdsx_note_t m;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] rng = 32'h000152E3;
  logic skip_pend = 1'b0;
  logic [1:0] ph_exp = 2'h0;
  cdsx_exec cdsx_exec_inst (.I_CORE_CLK(clk), .I_RST(rst), .I_INSTR(instr), .I_FILE_RDATA(rdata),
    .O_QPHASE(qphase), .O_FILE_ADDR(faddr), .O_FILE_RD(frd), .O_FILE_WR(fwr),
    .O_FILE_WDATA(fwd), .O_ACC_WR(awr), .O_ACC_WDATA(awd), .O_ZERO_WR(zwr),
    .O_ZERO_VAL(zval), .O_SKIP_NOP(skip), .O_BUSY(busy));
  initial
  begin
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  // drive at q4, note what the next cycle must show
  task automatic issue(input logic [5:0] op, input logic d, input logic [6:0] a,
    input logic [7:0] v);
    cdsx_note_t n;
    logic [7:0] r;
    logic act;
    do
    begin
      @(posedge clk);
      #1;
    end
    while (qphase !== 2'h3);
    instr = {op, d, a};
    rdata = v;
    act = op == cdsx_pkg::INVERT_REG_OP || op == cdsx_pkg::DEC_REG_OP;
    act = (act || op == cdsx_pkg::DEC_SKIP_IF_NULL_OP) && !skip_pend;
    r = (op == cdsx_pkg::INVERT_REG_OP) ? ~v : v - 8'h01;
    n = '{act && d, act && !d, r, act && op != cdsx_pkg::DEC_SKIP_IF_NULL_OP, r == 8'h00,
      skip_pend, act, a};
    skip_pend = act && op == cdsx_pkg::DEC_SKIP_IF_NULL_OP && r == 8'h00;
    notes.push_back(n);
  endtask : issue
  // watcher: compare each cycle at q2 and q4
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (rst)
        ph_exp = 2'h0;
      else
        ph_exp = ph_exp + 2'h1;
      #1;
      if (!rst)
        chk("qphase", 8'(ph_exp), 8'(qphase));
      if (!rst && notes.size() > 0 && qphase === 2'h1)
      begin
        chk("file_rd", 8'(notes[0].bz), 8'(frd));
        chk("early_strobe", 8'h00, 8'({fwr, awr, zwr}));
      end
      if (!rst && notes.size() > 0 && qphase === 2'h3)
      begin
        m = notes.pop_front();
        chk("file_wr", 8'(m.fw), 8'(fwr));
        chk("acc_wr", 8'(m.aw), 8'(awr));
        chk("zero_wr", 8'(m.zw), 8'(zwr));
        chk("skip_nop", 8'(m.sk), 8'(skip));
        chk("busy", 8'(m.bz), 8'(busy));
        if (m.bz)
          chk("file_addr", 8'(m.ad), 8'(faddr));
        if (m.fw)
          chk("file_wdata", m.wd, fwd);
        if (m.aw)
          chk("acc_wdata", m.wd, awd);
        if (m.zw)
          chk("zero_val", 8'(m.zv), 8'(zval));
      end
    end
  end
  initial
  begin
    #40us;
    n_errors++;
    test_done();
  end
  initial
  begin
    notes.push_back('{1'b0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00});
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    issue(cdsx_pkg::INVERT_REG_OP, 1'b0, 7'h0C, 8'h13);
    issue(cdsx_pkg::DEC_SKIP_IF_NULL_OP, 1'b1, 7'h20, 8'h01);
    issue(cdsx_pkg::INVERT_REG_OP, 1'b1, 7'h21, 8'hFF);
    issue(cdsx_pkg::DEC_REG_OP, 1'b0, 7'h7F, 8'h00);
    issue(cdsx_pkg::DEC_SKIP_IF_NULL_OP, 1'b0, 7'h01, 8'h02);
    issue(cdsx_pkg::INVERT_REG_OP, 1'b1, 7'h55, 8'hFF);
    $display("directed test done");
    repeat (400)
    begin
      rng = xs(rng);
      issue(rng[1:0] == 2'h0 ? cdsx_pkg::INVERT_REG_OP : rng[1:0] == 2'h1 ? cdsx_pkg::DEC_REG_OP :
        rng[1:0] == 2'h2 ? cdsx_pkg::DEC_SKIP_IF_NULL_OP : {1'b1, rng[12:8]}, rng[2], rng[30:24],
        rng[4:3] == 2'h0 ? {7'h00, rng[5]} : rng[23:16]);
    end
    $display("random test done");
    repeat (2) issue(6'h00, 1'b0, 7'h00, 8'h00);
    repeat (8) @(posedge clk);
    test_done();
  end
endmodule : testbench
